// >>> logic/timer0_cfg.svh
// register offsets, field positions, reset values for timer0 output control
`ifndef TIMER0_CFG_SVH
`define TIMER0_CFG_SVH
`define T0_CTRL_A_ADDR      8'h44
`define T0_CTRL_A_RESET     8'h00
`define T0_CHA_MODE_HI      7
`define T0_CHA_MODE_LO      6
`define T0_CHB_MODE_HI      5
`define T0_CHB_MODE_LO      4
`define T0_CHB_SHUT_BIT     3
`define T0_CHA_SHUT_BIT     2
`define T0_WGM_HI           1
`define T0_WGM_LO           0
`define T0_TRIG_SOURCES     4
`endif

// >>> logic/timer0_pkg.sv
// types shared by the timer0 output control files
package timer0_pkg;
    typedef logic [1:0] out_mode_t;
    typedef logic [2:0] wgm_t;
    typedef enum logic [1:0] {
        TRIG_COMPARATOR = 2'h0,
        TRIG_EXT_INT    = 2'h1,
        TRIG_PIN_CHANGE = 2'h2,
        TRIG_OVERFLOW   = 2'h3
    } trig_src_e;
endpackage

// >>> logic/shutdown_trigger.sv
// selects one trigger event from the four sources for a channel
module shutdown_trigger
    import timer0_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       arst_n,
    input  wire logic [1:0] trigger_select,
    input  wire logic [3:0] trigger_events,
    output logic            trigger
);
    // =========================================================
    // source selection
    wire logic selected;
    assign selected = trigger_events[trigger_select];
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            trigger <= 1'b0;
        end else begin
            trigger <= selected;
        end
    end
endmodule

// >>> logic/pin_mux.sv
// routes a compare waveform or the gpio value onto a pin
module pin_mux
    import timer0_pkg::*;
(
    input  wire logic      clock,
    input  wire logic      arst_n,
    input  wire out_mode_t mode,
    input  wire logic      compare_wave,
    input  wire logic      gpio_value,
    input  wire logic      gpio_dir_out,
    output logic           pin_out,
    output logic           pin_oe
);
    // =========================================================
    // output selection
    wire logic next_pin_out;
    // a zero mode field hands the pin back to gpio
    assign next_pin_out = (mode != 2'h0) ? compare_wave : gpio_value;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pin_out <= 1'b0;
            pin_oe  <= 1'b0;
        end else begin
            pin_out <= next_pin_out;
            pin_oe  <= gpio_dir_out;
        end
    end
endmodule

// >>> logic/timer0_output_control.sv
// timer0 output control register a with automatic pwm shutdown
//
// Decided for this implementation: strobed register access.
`include "timer0_cfg.svh"
module timer0_output_control
    import timer0_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              clock,
    input  wire logic              arst_n,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_write,
    input  wire logic              reg_read,
    output logic      [7:0]        reg_rdata,
    input  wire logic [1:0]        chan_a_trigger_select,
    input  wire logic [1:0]        chan_b_trigger_select,
    input  wire logic [3:0]        trigger_events,
    input  wire logic              waveform_gen_mode_top_bit,
    input  wire logic              chan_a_compare_out,
    input  wire logic              chan_b_compare_out,
    input  wire logic              gpio_a_value,
    input  wire logic              gpio_b_value,
    input  wire logic              gpio_a_dir_out,
    input  wire logic              gpio_b_dir_out,
    output logic                   chan_a_pin_out,
    output logic                   chan_a_pin_oe,
    output logic                   chan_b_pin_out,
    output logic                   chan_b_pin_oe,
    output logic      [2:0]        waveform_gen_mode
);
    // =========================================================
    // register state
    logic [7:0] timer0_output_control_a;
    wire logic  hit;
    wire logic  wr_hit;
    wire logic  trig_a;
    wire logic  trig_b;
    wire logic  shut_a;
    wire logic  shut_b;
    wire logic [7:0] next_ctrl;
    wire logic [7:0] written;

    assign hit    = (reg_addr == ADDR_W'(`T0_CTRL_A_ADDR));
    assign wr_hit = reg_write && hit;
    assign written = wr_hit ? reg_wdata : timer0_output_control_a;

    // =========================================================
    // trigger selection per channel
    shutdown_trigger trig_a_sel (
        .clock          (clock),
        .arst_n         (arst_n),
        .trigger_select (chan_a_trigger_select),
        .trigger_events (trigger_events),
        .trigger        (trig_a)
    );
    shutdown_trigger trig_b_sel (
        .clock          (clock),
        .arst_n         (arst_n),
        .trigger_select (chan_b_trigger_select),
        .trigger_events (trigger_events),
        .trigger        (trig_b)
    );

    // shutdown uses the enable as currently stored; a trigger beats a
    // same-cycle software rewrite of the mode field so no event is lost
    assign shut_a = trig_a && timer0_output_control_a[`T0_CHA_SHUT_BIT];
    assign shut_b = trig_b && timer0_output_control_a[`T0_CHB_SHUT_BIT];

    assign next_ctrl = {
        shut_a ? 2'h0 : written[`T0_CHA_MODE_HI:`T0_CHA_MODE_LO],
        shut_b ? 2'h0 : written[`T0_CHB_MODE_HI:`T0_CHB_MODE_LO],
        written[`T0_CHB_SHUT_BIT:`T0_WGM_LO]
    };

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            timer0_output_control_a <= `T0_CTRL_A_RESET;
        end else begin
            timer0_output_control_a <= next_ctrl;
        end
    end

    // =========================================================
    // read port: one cycle latency, unmapped reads return zero
    wire logic [7:0] next_rdata;
    assign next_rdata = (reg_read && hit) ? timer0_output_control_a : 8'h00;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // =========================================================
    // waveform mode output
    wire logic [2:0] next_wgm;
    assign next_wgm = {waveform_gen_mode_top_bit,
                       timer0_output_control_a[`T0_WGM_HI:`T0_WGM_LO]};
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            waveform_gen_mode <= 3'h0;
        end else begin
            waveform_gen_mode <= next_wgm;
        end
    end

    // =========================================================
    // pin routing
    pin_mux mux_a (
        .clock        (clock),
        .arst_n       (arst_n),
        .mode         (timer0_output_control_a[`T0_CHA_MODE_HI:`T0_CHA_MODE_LO]),
        .compare_wave (chan_a_compare_out),
        .gpio_value   (gpio_a_value),
        .gpio_dir_out (gpio_a_dir_out),
        .pin_out      (chan_a_pin_out),
        .pin_oe       (chan_a_pin_oe)
    );
    pin_mux mux_b (
        .clock        (clock),
        .arst_n       (arst_n),
        .mode         (timer0_output_control_a[`T0_CHB_MODE_HI:`T0_CHB_MODE_LO]),
        .compare_wave (chan_b_compare_out),
        .gpio_value   (gpio_b_value),
        .gpio_dir_out (gpio_b_dir_out),
        .pin_out      (chan_b_pin_out),
        .pin_oe       (chan_b_pin_oe)
    );

    // =========================================================
    // checks
    a_read_data_match: assert property (@(posedge clock) disable iff (!arst_n)
        reg_read && hit |=> reg_rdata == $past(timer0_output_control_a))
        else $error("read data mismatch");
    a_write_stores: assert property (@(posedge clock) disable iff (!arst_n)
        wr_hit && !shut_a && !shut_b |=> timer0_output_control_a == $past(reg_wdata))
        else $error("write not stored");
    a_unmapped_zero: assert property (@(posedge clock) disable iff (!arst_n)
        reg_read && !hit |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_chb_shutdown: assert property (@(posedge clock) disable iff (!arst_n)
        shut_b |=> timer0_output_control_a[5:4] == 2'h0)
        else $error("channel b mode not cleared");
    a_chb_ignored: assert property (@(posedge clock) disable iff (!arst_n)
        !timer0_output_control_a[3] && !wr_hit |=> $stable(timer0_output_control_a[5:4]))
        else $error("channel b mode changed without write");
    a_cha_shutdown: assert property (@(posedge clock) disable iff (!arst_n)
        shut_a |=> timer0_output_control_a[7:6] == 2'h0 ##2 chan_a_pin_out == $past(gpio_a_value))
        else $error("channel a not shut down");
    a_cha_kept: assert property (@(posedge clock) disable iff (!arst_n)
        !timer0_output_control_a[2] && !wr_hit |=> $stable(timer0_output_control_a[7:6]))
        else $error("channel a mode changed without write");
    a_pin_a_wave: assert property (@(posedge clock) disable iff (!arst_n)
        timer0_output_control_a[7:6] != 2'h0 |=> chan_a_pin_out == $past(chan_a_compare_out))
        else $error("channel a wave not on pin");
    a_pin_b_gpio: assert property (@(posedge clock) disable iff (!arst_n)
        timer0_output_control_a[5:4] == 2'h0 |=> chan_b_pin_out == $past(gpio_b_value))
        else $error("channel b pin not gpio");
    a_wgm_value: assert property (@(posedge clock) disable iff (!arst_n)
        1'b1 |=> waveform_gen_mode == {$past(waveform_gen_mode_top_bit),
                                       $past(timer0_output_control_a[1:0])})
        else $error("waveform mode wrong");
endmodule

// >>> tb/test_timer0_output_control.sv
// self-checking testbench for the timer0 output control register
`include "timer0_cfg.svh"
`define CHECK(got, exp, msg) begin n_checks++; if ((got) !== (exp)) begin failures++; \
    $display("CHECK FAILED %0t %s", $time, msg); end end
module test_timer0_output_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clock = 1'b0;
    logic       arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_write = 1'b0;
    logic       reg_read = 1'b0;
    logic [7:0] reg_rdata;
    logic [1:0] sel = 2'h0;
    logic [1:0] sel_b = 2'h0;
    logic       wave = 1'b1;
    logic       gpio = 1'b0;
    logic [3:0] trigger_events = 4'h0;
    logic       top_bit = 1'b0;
    logic       dir_out = 1'b1;
    logic       pin_a;
    logic       oe_a;
    logic       pin_b;
    logic       oe_b;
    logic [2:0] waveform_gen_mode;
    int         failures = 0;
    int         n_checks = 0;
    timer0_output_control dut_u (.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .chan_a_trigger_select(sel), .chan_b_trigger_select(sel_b),
        .trigger_events(trigger_events), .waveform_gen_mode_top_bit(top_bit),
        .chan_a_compare_out(wave), .chan_b_compare_out(wave), .gpio_a_value(gpio),
        .gpio_b_value(gpio), .gpio_a_dir_out(dir_out), .gpio_b_dir_out(dir_out),
        .chan_a_pin_out(pin_a), .chan_a_pin_oe(oe_a), .chan_b_pin_out(pin_b),
        .chan_b_pin_oe(oe_b), .waveform_gen_mode(waveform_gen_mode));
    always #4 clock = ~clock;
    // ==========================================
    // bus helpers
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    // pins are registered, so allow two edges before looking
    task automatic settle();
        repeat (2) @(posedge clock);
        #1;
    endtask
    // one-cycle event pulse, then wait out the three-edge shutdown latency
    task automatic fire(input int idx);
        @(posedge clock);
        trigger_events <= 4'h1 << idx;
        @(posedge clock);
        trigger_events <= 4'h0;
        repeat (3) @(posedge clock);
        #1;
    endtask
    // ==========================================
    // scenarios
    task automatic t_regs();
        logic [7:0] d;
        rd(`T0_CTRL_A_ADDR, d);
        `CHECK(d, 8'h00, "reset value")
        wr(`T0_CTRL_A_ADDR, 8'hA5);
        rd(`T0_CTRL_A_ADDR, d);
        `CHECK(d, 8'hA5, "readback")
        wr(8'h45, 8'hFF);
        rd(`T0_CTRL_A_ADDR, d);
        `CHECK(d, 8'hA5, "unmapped write leaked")
        rd(8'h45, d);
        `CHECK(d, 8'h00, "unmapped read")
        top_bit <= 1'b1;
        wr(`T0_CTRL_A_ADDR, 8'h5A);
        rd(`T0_CTRL_A_ADDR, d);
        `CHECK(d, 8'h5A, "readback inverse")
        `CHECK(waveform_gen_mode, 3'h6, "mode combine")
    endtask
    task automatic t_pins();
        for (int m = 0; m < 4; m++) begin
            wr(`T0_CTRL_A_ADDR, {m[1:0], m[1:0], 4'h0});
            settle();
            `CHECK(pin_a, m != 0, "pin a select")
            `CHECK(pin_b, m != 0, "pin b select")
        end
        wave <= 1'b0;
        settle();
        `CHECK({pin_a, pin_b}, 2'b00, "wave not followed")
        wave <= 1'b1;
        dir_out <= 1'b0;
        settle();
        `CHECK({oe_a, oe_b}, 2'b00, "direction input")
        dir_out <= 1'b1;
        settle();
        `CHECK({oe_a, oe_b}, 2'b11, "direction output")
    endtask
    task automatic t_shut();
        logic [7:0] d;
        for (int s = 0; s < 4; s++) begin
            sel <= s[1:0];
            sel_b <= s[1:0];
            wr(`T0_CTRL_A_ADDR, 8'hF1);
            fire(s);
            rd(`T0_CTRL_A_ADDR, d);
            `CHECK(d, 8'hF1, "disabled shutdown acted")
            `CHECK({pin_a, pin_b}, 2'b11, "wave lost")
            wr(`T0_CTRL_A_ADDR, 8'hFD);
            fire((s + 1) % 4);
            rd(`T0_CTRL_A_ADDR, d);
            `CHECK(d, 8'hFD, "wrong source acted")
            fire(s);
            rd(`T0_CTRL_A_ADDR, d);
            `CHECK(d, 8'h0D, "fields not cleared")
            `CHECK({pin_a, pin_b}, 2'b00, "pins not gpio")
            `CHECK({oe_a, oe_b}, 2'b11, "gpio drive lost")
        end
        // separate sources per channel: only the matching channel shuts down
        sel <= 2'h3;
        sel_b <= 2'h1;
        wr(`T0_CTRL_A_ADDR, 8'hFD);
        fire(3);
        rd(`T0_CTRL_A_ADDR, d);
        `CHECK(d, 8'h3D, "channel a source")
        `CHECK({pin_a, pin_b}, 2'b01, "only a to gpio")
        fire(1);
        rd(`T0_CTRL_A_ADDR, d);
        `CHECK(d, 8'h0D, "channel b source")
        gpio <= 1'b1;
        settle();
        `CHECK({pin_a, pin_b}, 2'b11, "gpio value not on pins")
        gpio <= 1'b0;
    endtask
    // ==========================================
    // verdict and main sequence
    task automatic give_verdict();
        if (failures == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clock);
        arst_n <= 1'b1;
        t_regs();
        t_pins();
        t_shut();
        give_verdict();
    end
    initial begin
        #100000;
        failures++;
        give_verdict();
    end
endmodule
